//--- pwg_cfg.svh
`ifndef PWG_CFG_SVH
`define PWG_CFG_SVH

// ----------------------------------------
// register map (word index on the plain port)
// ----------------------------------------
`define PWG_ADDR_PERIOD 3'h0
`define PWG_ADDR_TBCTL 3'h1
`define PWG_ADDR_DUTY 3'h2
`define PWG_ADDR_MODCTL 3'h3
`define PWG_ADDR_COUNT 3'h4
`define PWG_ADDR_ACTIVE 3'h5
`define PWG_ADDR_PINSEL 3'h6

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PWG_TB_PS_LSB 0
`define PWG_TB_ON_BIT 2
`define PWG_TB_POST_LSB 3
`define PWG_TB_MASK 8'h7f
`define PWG_MC_DLO_LSB 4
`define PWG_MC_MODE_LSB 0
`define PWG_MC_MASK 8'h3f
`define PWG_MODE_PWM 4'hc
`define PWG_PERIOD_RST 8'hff
`define PWG_ZERO8 8'h00
`define PWG_PH_LAST 2'h3
`define PWG_PRE4_LAST 2'h3
`define PWG_PRE16_LAST 4'hf

`endif

//--- pwg_load.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// load on the pin
// ---
module pwg_load (
   input wire logic clock,
   input wire logic pin,
   output int hi,
   output int per
);
   int h = 0, p = 0;
   logic last = 1'b0;
   // pin taken as a driven output, never read back
   always @(posedge clock) begin
      last <= pin;
      if (pin && !last) begin
         per <= p;
         hi <= h;
         p <= 1;
         h <= 1;
      end else begin
         p <= p + 1;
         h <= h + int'(pin);
      end
   end
endmodule
`default_nettype wire

//--- pwg_pkg.sv
`default_nettype none
package pwg_pkg;
   typedef logic [1:0] pwg_ps_t;
   typedef struct packed {
      logic [7:0] cnt;
      logic [1:0] ph;
      logic [3:0] pre;
      logic [7:0] adl;
      logic [1:0] alo;
      logic out;
   } pwg_tb_s;
   typedef struct packed {
      logic [7:0] period;
      logic [6:0] tbctl;
      logic [5:0] modctl;
      logic [7:0] dbuf;
      logic pinsel;
      logic [7:0] rdata;
      logic pin_a;
      logic pin_b;
      logic own_a;
      logic own_b;
   } pwg_top_s;
endpackage
`default_nettype wire

//--- pwg_timebase.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwg_cfg.svh"

module pwg_timebase (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic run,
   input wire logic active,
   input wire logic [1:0] ps_sel,
   input wire logic [7:0] period,
   input wire logic [7:0] duty_hi,
   input wire logic [1:0] duty_lo,
   output logic [7:0] count,
   output logic [7:0] active_duty,
   output logic wave
);
   pwg_pkg::pwg_tb_s s_q, s_d;
   logic inc;
   logic [1:0] ext;
   logic [9:0] tb10;

   always_comb begin
      s_d = s_q;
      inc = 1'b0;
      ext = s_q.ph;
      if (run) begin
         // fosc phase counter; instruction cycle every four clocks
         s_d.ph = s_q.ph + 2'h1;
         if (s_q.ph == `PWG_PH_LAST) begin
            s_d.pre = s_q.pre + 4'h1;
            case (ps_sel)
               2'h0: inc = 1'b1;
               2'h1: inc = (s_q.pre[1:0] == `PWG_PRE4_LAST);
               default: inc = (s_q.pre == `PWG_PRE16_LAST);
            endcase
         end
      end
      tb10 = 10'h000;
      if (inc) begin
         if (s_q.cnt == period) begin
            // period match: clear, reload duty, set pin unless new duty is zero
            s_d.cnt = `PWG_ZERO8;
            s_d.adl = duty_hi;
            s_d.alo = duty_lo;
            s_d.out = ({duty_hi, duty_lo} != 10'h000);
         end else begin
            s_d.cnt = s_q.cnt + 8'h1;
         end
      end
      // low timebase bits: fosc phase at 1:1, else prescaler bits
      // next base value compared, so the registered pin falls as the base reaches duty
      case (ps_sel)
         2'h0: ext = s_d.ph;
         2'h1: ext = s_d.pre[1:0];
         default: ext = s_d.pre[3:2];
      endcase
      tb10 = {s_d.cnt, ext};
      // clear on duty match; never reached if duty beyond period
      if (run && !(inc && s_q.cnt == period) && tb10 == {s_q.adl, s_q.alo}) begin
         s_d.out = 1'b0;
      end
      if (!active) begin
         s_d.out = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.cnt;
   assign active_duty = s_q.adl;
   assign wave = s_q.out;
endmodule
`default_nettype wire

//--- pwg_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwg_cfg.svh"

// How it works
// - output pin carries 10-bit resolution pwm
// - second unit output selectable between two pins
// - zero control register releases pin ownership
// - period is (period+1) times 4 times prescale
// - counter clears on increment after period match
// - pin set on match unless duty zero
// - duty buffer copied to active latch on match
// - postscaler never affects pwm frequency
// - duty: eight high bits plus two low
// - active duty latch read-only, double buffered
// - low timebase bits from phase or prescaler
// - timebase equal duty clears the pin
module pwg_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic pwm_output_pin_a,
   output logic pwm_output_pin_b,
   output logic pin_own_a,
   output logic pin_own_b
);
   pwg_pkg::pwg_top_s s_q, s_d;
   logic [7:0] count;
   logic [7:0] active_duty;
   logic wave;
   logic pwm_mode;

   // ----------------------------------------
   // timebase and comparator
   // ----------------------------------------
   assign pwm_mode = (s_q.modctl[3:0] == `PWG_MODE_PWM);

   pwg_timebase u_tb (
      .clock(clock),
      .reset_n(reset_n),
      .run(s_q.tbctl[`PWG_TB_ON_BIT]),
      .active(pwm_mode),
      .ps_sel(s_q.tbctl[`PWG_TB_PS_LSB +: 2]),
      .period(s_q.period),
      .duty_hi(s_q.dbuf),
      .duty_lo(s_q.modctl[`PWG_MC_DLO_LSB +: 2]),
      .count(count),
      .active_duty(active_duty),
      .wave(wave)
   );

   // ----------------------------------------
   // register port and pin steering
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rdata = `PWG_ZERO8;
      if (wr) begin
         case (addr)
            `PWG_ADDR_PERIOD: s_d.period = wdata;
            // postscale bits stored only, unused by the pwm path
            `PWG_ADDR_TBCTL: s_d.tbctl = wdata[6:0];
            `PWG_ADDR_DUTY: s_d.dbuf = wdata;
            `PWG_ADDR_MODCTL: s_d.modctl = wdata[5:0];
            `PWG_ADDR_PINSEL: s_d.pinsel = wdata[0];
            default: s_d.period = s_q.period;
         endcase
      end
      if (rd) begin
         case (addr)
            `PWG_ADDR_PERIOD: s_d.rdata = s_q.period;
            `PWG_ADDR_TBCTL: s_d.rdata = {1'b0, s_q.tbctl};
            `PWG_ADDR_DUTY: s_d.rdata = s_q.dbuf;
            `PWG_ADDR_MODCTL: s_d.rdata = {2'h0, s_q.modctl};
            `PWG_ADDR_COUNT: s_d.rdata = count;
            // writes to the active latch have no decode: read-only
            `PWG_ADDR_ACTIVE: s_d.rdata = active_duty;
            `PWG_ADDR_PINSEL: s_d.rdata = {7'h00, s_q.pinsel};
            default: s_d.rdata = `PWG_ZERO8;
         endcase
      end
      // zero control register hands the pin back to the port
      // pin direction still belongs to the port logic outside
      s_d.own_a = pwm_mode && !s_q.pinsel;
      s_d.own_b = pwm_mode && s_q.pinsel;
      s_d.pin_a = wave && !s_q.pinsel;
      s_d.pin_b = wave && s_q.pinsel;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.period <= `PWG_PERIOD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign pwm_output_pin_a = s_q.pin_a;
   assign pwm_output_pin_b = s_q.pin_b;
   assign pin_own_a = s_q.own_a;
   assign pin_own_b = s_q.own_b;
endmodule
`default_nettype wire

//--- pwg_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// port checks
// ---
module pwg_top_sva (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic pwm_output_pin_a,
   input wire logic pwm_output_pin_b,
   input wire logic pin_own_a,
   input wire logic pin_own_b
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   property p_excl; !(pin_own_a && pin_own_b); endproperty
   a_excl: assert property (p_excl) else $error("both pins owned");
   property p_rel_a; !pin_own_a [*3] |-> !pwm_output_pin_a; endproperty
   a_rel_a: assert property (p_rel_a) else $error("pin a driven unowned");
   property p_rel_b; !pin_own_b [*3] |-> !pwm_output_pin_b; endproperty
   a_rel_b: assert property (p_rel_b) else $error("pin b driven unowned");
   property p_zero; wr && addr == 3'h3 && wdata == 8'h00 |-> ##[1:2] !(pin_own_a || pin_own_b);
   endproperty
   a_zero: assert property (p_zero) else $error("pin not released");
   property p_up_a; $rose(pwm_output_pin_a) |-> pin_own_a || $past(pin_own_a); endproperty
   a_up_a: assert property (p_up_a) else $error("pin a rose unowned");
   property p_up_b; $rose(pwm_output_pin_b) |-> pin_own_b || $past(pin_own_b); endproperty
   a_up_b: assert property (p_up_b) else $error("pin b rose unowned");
   property p_gap; $rose(pwm_output_pin_a) |=> !$rose(pwm_output_pin_a) [*3]; endproperty
   a_gap: assert property (p_gap) else $error("period under four clocks");
   property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data outside slot");
   cover property ($rose(pwm_output_pin_a));
   cover property ($rose(pwm_output_pin_b));
   cover property (wr && addr == 3'h3 && wdata == 8'h00);
endmodule
bind pwg_top pwg_top_sva u_sva (.clock, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
   .pwm_output_pin_a, .pwm_output_pin_b, .pin_own_a, .pin_own_b);
`default_nettype wire

//--- pwg_top_test.sv
`timescale 1ns/100ps
`default_nettype none
// ---
// bench
// ---
module pwg_top_test;
   logic clock = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, pa, pb, oa, ob;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata;
   int err_total = 0, n_tests = 0, hi, per, p, s, ps, dt, full, tp, h, g;
   always #5 clock = ~clock;
   pwg_top DUT (.clock, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .pwm_output_pin_a(pa),
      .pwm_output_pin_b(pb), .pin_own_a(oa), .pin_own_b(ob));
   pwg_load u_load (.clock, .pin(pa | pb), .hi(hi), .per(per));
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
      n_tests++;
      if (v !== e) begin
         err_total++;
         $display("[ERR] %0t seen %0h expected %0h", $time, v, e);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
      @(posedge clock);
      {addr, rd} <= {a, 1'b1};
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk(rdata, e);
   endtask
   task automatic rst;
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
   endtask
   task automatic summarize;
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(43969));
      rst();
      rd_chk(3'h0, 8'hff);
      rd_chk(3'h1, 8'h00);
      rd_chk(3'h4, 8'h00);
      for (int i = 0; i < 5; i++) begin
         p = $urandom % 8;
         s = $urandom % 4;
         full = 4 * (p + 1);
         dt = i == 0 ? 0 : $urandom % (full + 4);
         ps = s == 0 ? 1 : s == 1 ? 4 : 16;
         tp = full * ps;
         rst();
         wr_reg(3'h6, 8'(i % 2));
         wr_reg(3'h0, 8'(p));
         wr_reg(3'h2, 8'(dt >> 2));
         wr_reg(3'h3, 8'(12 + (dt % 4) * 16));
         wr_reg(3'h1, 8'(($urandom % 16) * 8 + 4 + s));
         repeat (3 * tp) @(posedge clock);
         rd_chk(3'h5, 8'(dt >> 2));
         wr_reg(3'h5, 8'hff);
         rd_chk(3'h5, 8'(dt >> 2));
         rd_chk(3'h7, 8'h00);
         chk(32'({oa, ob}), i % 2 ? 32'h1 : 32'h2);
         h = 0;
         g = 0;
         repeat (2 * tp) begin
            @(negedge clock);
            h += i % 2 ? pb : pa;
            g += i % 2 ? pa : pb;
         end
         chk(g, 0);
         // window of whole periods: phase does not matter
         chk(h, 2 * (dt < full ? dt : full) * ps);
         if (dt > 0 && dt < full) chk(per, tp);
         if (dt > 0 && dt < full) chk(hi, dt * ps);
      end
      wr_reg(3'h3, 8'h00);
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk(oa | ob, 0);
      summarize();
   end
   initial begin
      #300000;
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
